// >>> rtl/nd_pkg.sv
// Constants, register map and state type for the one-time value block.
// Assumes a 32-bit classic Wishbone slave decoding byte addresses.
package nd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_NONCE_MODE = 8'h04;
  localparam logic [7:0] ADR_SECOND_PARAMETER = 8'h08;
  localparam logic [7:0] ADR_IN_LEN = 8'h0c;
  localparam logic [7:0] ADR_MAC_MODE = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADR_RESP_LEN = 8'h1c;
  localparam logic [7:0] ADR_HOST_IN = 8'h20;
  localparam logic [7:0] ADR_RESP = 8'h40;
  localparam logic [7:0] ADR_WIN_MASK = 8'he0;

  // Control and status fields
  localparam int CTRL_GO_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_KEY_OK_BIT = 2;
  localparam int ST_ORIGIN_BIT = 3;

  // Interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_MAC_ERR_BIT = 2;

  // Reset values
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [5:0] RST_IN_LEN = 6'h14;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_SECOND_PARAMETER = 16'h0000;

  // Command encoding
  localparam logic [7:0] NONCE_OPCODE = 8'h16;
  localparam logic [5:0] LEN_SHORT = 6'h14;
  localparam logic [5:0] LEN_FULL = 6'h20;
  localparam logic [5:0] LEN_ONE = 6'h01;
  localparam logic [1:0] MODE_RAND_SEED = 2'b00;
  localparam logic [1:0] MODE_RAND_KEEP = 2'b01;
  localparam logic [1:0] MODE_BAD = 2'b10;
  localparam logic [1:0] MODE_PASS = 2'b11;
  localparam int P2_SCRATCH_BIT = 15;
  localparam logic ORIGIN_RAND = 1'b0;
  localparam logic ORIGIN_INPUT = 1'b1;

  // Keyed-digest mode fields
  localparam int MAC_SN_BIT = 6;
  localparam int MAC_ORIGIN_BIT = 2;
  localparam int MAC_FIRST_BIT = 1;
  localparam int MAC_SECOND_BIT = 0;

  // Generator output while configuration is unlocked, repeated to 32 bytes
  localparam logic [63:0] TEST_PATTERN = 64'hffff0000ffff0000;
  localparam int KEY_W = 256;
  localparam int MSG_W = 440;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_RNG = 3'b010,
    ST_HASH = 3'b011,
    ST_WAIT = 3'b100,
    ST_FIN = 3'b101
  } nd_state_t;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] nd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : nd_merge
endpackage : nd_pkg

// >>> rtl/nd_mac_if.sv
// Carrier between the command block and its keyed-digest mode decoder.
// Assumes both ends sit on the same clock; the decoder is combinational.
`timescale 1ns/10ps
interface nd_mac_if;
  logic [7:0] mode;
  logic origin;
  logic [47:0] sn_in;
  logic first_key;
  logic second_key;
  logic origin_err;
  logic [47:0] sn_field;
  modport dec (input mode, input origin, input sn_in,
               output first_key, output second_key, output origin_err, output sn_field);
  modport top (output mode, output origin, output sn_in,
               input first_key, input second_key, input origin_err, input sn_field);
endinterface : nd_mac_if

// >>> rtl/nd_mac_decode.sv
// Decoder for the mode byte of the keyed-digest command.
// Assumes the caller registers the results before they leave the block.
`timescale 1ns/10ps
module nd_mac_decode (
  // Mode in, selections out
  nd_mac_if.dec mi
);
  import nd_pkg::*;

  assign mi.sn_field = mi.mode[MAC_SN_BIT] ? mi.sn_in : 48'h000000000000;
  assign mi.first_key = mi.mode[MAC_FIRST_BIT];
  assign mi.second_key = mi.mode[MAC_SECOND_BIT];
  // Origin only matters when the scratch key feeds the message
  assign mi.origin_err = (mi.mode[MAC_FIRST_BIT] | mi.mode[MAC_SECOND_BIT]) &
                         (mi.mode[MAC_ORIGIN_BIT] != mi.origin);
endmodule : nd_mac_decode

// >>> rtl/nd_nonce_top.sv
// One-time value command and keyed-digest mode logic behind a Wishbone slave.
// Assumes an external hash engine and random generator on REF_CLK.
//
// Notes on behaviour
// - Digest mode bit 6 clear zeroes serial bytes
// - Key-fed digest needs bit 2 equal origin
// - Digest bit 1 picks slot or scratch key
// - Digest bit 0 picks challenge or scratch key
// - Random modes store digest, set valid, origin random
// - Random modes hash random, input, opcode, mode, param
// - Param bit 15 reuses scratch key, flags kept
// - Mode one suppresses seed update
// - Mode zero updates seed only when needed
// - Mode three copies 32 bytes, origin input
// - Unlocked configuration yields fixed test pattern
// - Output is 32 bytes or one zero
`timescale 1ns/10ps
module nd_nonce_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Interrupt
  output logic IRQ,
  // Configuration lock pin
  input wire logic CFG_LOCKED,
  // Random generator
  output logic RNG_REQ,
  output logic RNG_SEED_UPDATE,
  input wire logic RNG_DONE,
  input wire logic [nd_pkg::KEY_W-1:0] RNG_DATA,
  // Hash engine
  output logic HASH_REQ,
  output logic [nd_pkg::MSG_W-1:0] HASH_MSG,
  input wire logic HASH_DONE,
  input wire logic [nd_pkg::KEY_W-1:0] HASH_DIGEST,
  // Keyed-digest mode decode
  input wire logic [47:0] SERIAL_NUMBER_BYTES,
  output logic MAC_FIRST_KEY,
  output logic MAC_SECOND_KEY,
  output logic [47:0] MAC_SN_FIELD
);
  import nd_pkg::*;

  nd_state_t state_ff, nxt_state;
  logic [1:0] lock_sync_ff;
  logic [7:0] mode_ff;
  logic [15:0] second_parameter_ff;
  logic [5:0] in_len_ff;
  logic [7:0] mac_mode_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [31:0] host_in_ff [0:7];
  logic [KEY_W-1:0] scratch_key_reg_ff, rnd_ff, response_bytes_ff;
  logic [5:0] resp_len_ff;
  logic scratch_key_ok_ff, key_origin_flag_ff, err_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic mac_chk_ff;
  logic [KEY_W-1:0] host_input_value;
  logic wb_req, wr, rd, go, use_key, bad_cmd;
  logic ev_done, ev_err, ev_mac_err;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  nd_mac_if mi ();
  nd_mac_decode u_dec (
    .mi(mi)
  );
  assign mi.mode = mac_mode_ff;
  assign mi.origin = key_origin_flag_ff;
  assign mi.sn_in = SERIAL_NUMBER_BYTES;

  // Byte 0 of the input is the most significant byte of word 0
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_in
      assign host_input_value[KEY_W-1-32*gi -: 32] = host_in_ff[gi];
    end
  endgenerate

  // Bus decode
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wr = wb_req & WB_WE_I;
  assign rd = wb_req & ~WB_WE_I;
  assign go = wr & (WB_ADR_I == ADR_CTRL) & WB_SEL_I[0] & WB_DAT_I[CTRL_GO_BIT] &
              (state_ff == ST_IDLE);
  assign use_key = second_parameter_ff[P2_SCRATCH_BIT];
  assign bad_cmd = (mode_ff[1:0] == MODE_BAD) |
                   ((mode_ff[1:0] == MODE_PASS) ? (in_len_ff != LEN_FULL)
                                                : (in_len_ff != LEN_SHORT));

  // Pin crossing: first stage is read only by the second
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lock_sync_ff <= 2'b00;
    else
      lock_sync_ff <= {lock_sync_ff[0], CFG_LOCKED};
  end

  // Command state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (go) nxt_state = ST_CHECK;
      ST_CHECK:
      begin
        if (bad_cmd || mode_ff[1:0] == MODE_PASS)
          nxt_state = ST_FIN;
        else if (use_key)
          nxt_state = ST_HASH;
        else
          nxt_state = ST_RNG;
      end
      ST_RNG: if (RNG_DONE) nxt_state = ST_HASH;
      ST_HASH: nxt_state = ST_WAIT;
      ST_WAIT: if (HASH_DONE) nxt_state = ST_FIN;
      ST_FIN: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Nonce command registers are frozen while a command runs; digest mode and mask are not
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_ff <= RST_MODE;
      second_parameter_ff <= RST_SECOND_PARAMETER;
      in_len_ff <= RST_IN_LEN;
      mac_mode_ff <= RST_MODE;
      irq_mask_ff <= RST_IRQ_MASK;
      mac_chk_ff <= 1'b0;
    end
    else
    begin
      mac_chk_ff <= wr & (WB_ADR_I == ADR_MAC_MODE) & WB_SEL_I[0];
      if (wr && state_ff == ST_IDLE)
      begin
        if (WB_ADR_I == ADR_NONCE_MODE && WB_SEL_I[0])
          mode_ff <= WB_DAT_I[7:0];
        if (WB_ADR_I == ADR_SECOND_PARAMETER)
          second_parameter_ff <= 16'(nd_merge({16'h0000, second_parameter_ff}, WB_DAT_I,
                                              WB_SEL_I));
        if (WB_ADR_I == ADR_IN_LEN && WB_SEL_I[0])
          in_len_ff <= WB_DAT_I[5:0];
      end
      if (wr && WB_ADR_I == ADR_MAC_MODE && WB_SEL_I[0])
        mac_mode_ff <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == ADR_IRQ_MASK && WB_SEL_I[0])
        irq_mask_ff <= WB_DAT_I[IRQ_W-1:0];
    end
  end

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_hin
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          host_in_ff[gi] <= 32'h00000000;
        else if (wr && state_ff == ST_IDLE &&
                 WB_ADR_I == ADR_HOST_IN + 8'(4*gi))
          host_in_ff[gi] <= nd_merge(host_in_ff[gi], WB_DAT_I, WB_SEL_I);
      end
    end
  endgenerate

  // Random value and generator requests
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rnd_ff <= '0;
      RNG_REQ <= 1'b0;
      RNG_SEED_UPDATE <= 1'b0;
    end
    else
    begin
      RNG_REQ <= (state_ff == ST_CHECK) && (nxt_state == ST_RNG);
      if (state_ff == ST_CHECK && nxt_state == ST_RNG)
        RNG_SEED_UPDATE <= (mode_ff[1:0] == MODE_RAND_SEED);
      if (state_ff == ST_CHECK && use_key)
        rnd_ff <= scratch_key_reg_ff;
      else if (state_ff == ST_RNG && RNG_DONE)
        rnd_ff <= lock_sync_ff[1] ? RNG_DATA : {4{TEST_PATTERN}};
    end
  end

  // Hash request with the assembled message
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      HASH_REQ <= 1'b0;
      HASH_MSG <= '0;
    end
    else
    begin
      HASH_REQ <= (state_ff == ST_HASH);
      if (state_ff == ST_HASH)
        HASH_MSG <= {rnd_ff, host_input_value[KEY_W-1 -: 160], NONCE_OPCODE, mode_ff,
                     second_parameter_ff[7:0]};
    end
  end

  // Scratch key, its flags and the response
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scratch_key_reg_ff <= '0;
      scratch_key_ok_ff <= 1'b0;
      key_origin_flag_ff <= ORIGIN_RAND;
      response_bytes_ff <= '0;
      resp_len_ff <= 6'h00;
      err_ff <= 1'b0;
    end
    else if (state_ff == ST_CHECK)
    begin
      err_ff <= bad_cmd;
      if (!bad_cmd && mode_ff[1:0] == MODE_PASS)
      begin
        scratch_key_reg_ff <= host_input_value;
        scratch_key_ok_ff <= 1'b1;
        key_origin_flag_ff <= ORIGIN_INPUT;
        response_bytes_ff <= '0;
        resp_len_ff <= LEN_ONE;
      end
    end
    else if (state_ff == ST_WAIT && HASH_DONE)
    begin
      scratch_key_reg_ff <= HASH_DIGEST;
      resp_len_ff <= LEN_FULL;
      if (use_key)
        response_bytes_ff <= HASH_DIGEST;
      else
      begin
        response_bytes_ff <= rnd_ff;
        scratch_key_ok_ff <= 1'b1;
        key_origin_flag_ff <= ORIGIN_RAND;
      end
    end
  end

  // Registered digest-mode results
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      MAC_FIRST_KEY <= 1'b0;
      MAC_SECOND_KEY <= 1'b0;
      MAC_SN_FIELD <= 48'h000000000000;
    end
    else
    begin
      MAC_FIRST_KEY <= mi.first_key;
      MAC_SECOND_KEY <= mi.second_key;
      MAC_SN_FIELD <= mi.sn_field;
    end
  end

  // Interrupt status: a new event wins over the read that clears it
  assign ev_done = (state_ff == ST_FIN) & ~err_ff;
  assign ev_err = (state_ff == ST_FIN) & err_ff;
  assign ev_mac_err = mac_chk_ff & mi.origin_err;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      irq_stat_ff <= '0;
    else
    begin
      if (rd && WB_ADR_I == ADR_IRQ_STAT)
        irq_stat_ff <= {ev_mac_err, ev_err, ev_done};
      else
        irq_stat_ff <= irq_stat_ff | {ev_mac_err, ev_err, ev_done};
    end
  end

  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  // Read mux; unmapped addresses read as zero
  assign status_word = {28'h0000000, key_origin_flag_ff, scratch_key_ok_ff, err_ff,
                        state_ff != ST_IDLE};

  always_comb
  begin
    rd_mux = 32'h00000000;
    if ((WB_ADR_I & ADR_WIN_MASK) == ADR_HOST_IN)
      rd_mux = host_in_ff[WB_ADR_I[4:2]];
    else if ((WB_ADR_I & ADR_WIN_MASK) == ADR_RESP)
      rd_mux = response_bytes_ff[KEY_W-1-32*WB_ADR_I[4:2] -: 32];
    else
    begin
      case (WB_ADR_I)
        ADR_CTRL: rd_mux = status_word;
        ADR_NONCE_MODE: rd_mux = {24'h000000, mode_ff};
        ADR_SECOND_PARAMETER: rd_mux = {16'h0000, second_parameter_ff};
        ADR_IN_LEN: rd_mux = {26'h0000000, in_len_ff};
        ADR_MAC_MODE: rd_mux = {24'h000000, mac_mode_ff};
        ADR_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_ff};
        ADR_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_ff};
        ADR_RESP_LEN: rd_mux = {26'h0000000, resp_len_ff};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // One-wait-state acknowledge for every address, mapped or not
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= wb_req;
      if (rd)
        dat_ff <= rd_mux;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
endmodule : nd_nonce_top

// >>> verif/nd_nonce_props.sv
// Checker on the ports of the one-time value block.
// Assumes the host writes the mode registers only while the block is idle.
`timescale 1ns/10ps
module nd_nonce_props (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // Engines and decode
  input wire logic CFG_LOCKED,
  input wire logic RNG_REQ,
  input wire logic RNG_SEED_UPDATE,
  input wire logic RNG_DONE,
  input wire logic [nd_pkg::KEY_W-1:0] RNG_DATA,
  input wire logic HASH_REQ,
  input wire logic [nd_pkg::MSG_W-1:0] HASH_MSG,
  input wire logic [47:0] SERIAL_NUMBER_BYTES,
  input wire logic MAC_FIRST_KEY,
  input wire logic MAC_SECOND_KEY,
  input wire logic [47:0] MAC_SN_FIELD
);
  import nd_pkg::*;
  logic [7:0] nm_ff;
  logic [7:0] mac_ff;
  logic [15:0] p2_ff;
  logic [KEY_W-1:0] rng_ff;
  logic wr;
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
  // Shadows of the mode registers, taken at the same edge as the design
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      nm_ff <= RST_MODE;
      mac_ff <= 8'h00;
      p2_ff <= RST_SECOND_PARAMETER;
      rng_ff <= '0;
    end
    else
    begin
      if (wr && WB_ADR_I == ADR_NONCE_MODE)
        nm_ff <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == ADR_MAC_MODE)
        mac_ff <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == ADR_SECOND_PARAMETER)
        p2_ff <= WB_DAT_I[15:0];
      if (RNG_DONE)
        rng_ff <= RNG_DATA;
    end
  end
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acked");
  a_sn_field: assert property (MAC_SN_FIELD ==
    ($past(mac_ff[MAC_SN_BIT]) ? $past(SERIAL_NUMBER_BYTES) : 48'h0))
    else $error("serial field wrong");
  a_first_key: assert property (MAC_FIRST_KEY == $past(mac_ff[MAC_FIRST_BIT]))
    else $error("first source wrong");
  a_second_key: assert property (MAC_SECOND_KEY == $past(mac_ff[MAC_SECOND_BIT]))
    else $error("second source wrong");
  a_seed_mode: assert property (RNG_REQ |-> RNG_SEED_UPDATE == !nm_ff[0])
    else $error("seed update wrong");
  a_rng_skip: assert property (RNG_REQ |-> !p2_ff[P2_SCRATCH_BIT] && !nm_ff[1])
    else $error("random asked wrongly");
  a_hash_follow: assert property (RNG_DONE |-> ##[1:3] HASH_REQ)
    else $error("hash not started");
  a_msg_tail: assert property (HASH_REQ |-> !nm_ff[1] &&
    HASH_MSG[23:0] == {NONCE_OPCODE, nm_ff, p2_ff[7:0]})
    else $error("message tail wrong");
  a_msg_head: assert property (HASH_REQ && !p2_ff[P2_SCRATCH_BIT] |->
    HASH_MSG[MSG_W-1 -: KEY_W] == (CFG_LOCKED ? rng_ff : {4{TEST_PATTERN}}))
    else $error("message head wrong");
  c_scratch: cover property (HASH_REQ && p2_ff[P2_SCRATCH_BIT]);
  c_keep_seed: cover property (RNG_REQ && !RNG_SEED_UPDATE);
  c_serial: cover property (MAC_SN_FIELD != 48'h0);
endmodule : nd_nonce_props

bind nd_nonce_top nd_nonce_props nd_nonce_props_inst (.REF_CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .CFG_LOCKED, .RNG_REQ, .RNG_SEED_UPDATE,
  .RNG_DONE, .RNG_DATA, .HASH_REQ, .HASH_MSG, .SERIAL_NUMBER_BYTES, .MAC_FIRST_KEY,
  .MAC_SECOND_KEY, .MAC_SN_FIELD);

// >>> verif/nd_engine_model.sv
// Random generator and hash engine standing beside the block.
// Assumes one request at a time; the digest is a keyed xor of the message head.
`timescale 1ns/10ps
module nd_engine_model #(
  parameter logic [255:0] RVAL = '0,
  parameter logic [255:0] DXOR = '0
) (
  // Clock, reset and pace
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Engines
  input wire logic rng_req,
  output logic rng_done,
  output logic [nd_pkg::KEY_W-1:0] rng_data,
  input wire logic hash_req,
  input wire logic [nd_pkg::MSG_W-1:0] hash_msg,
  output logic hash_done,
  output logic [nd_pkg::KEY_W-1:0] hash_digest
);
  import nd_pkg::*;
  int rng_cnt_ff;
  int hash_cnt_ff;
  logic [KEY_W-1:0] dig_ff;
  // Data is inverted outside its pulse so a late capture cannot match by luck
  assign rng_data = rng_done ? RVAL : ~RVAL;
  assign hash_digest = hash_done ? dig_ff : ~dig_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rng_cnt_ff <= 0;
      hash_cnt_ff <= 0;
      rng_done <= 1'b0;
      hash_done <= 1'b0;
      dig_ff <= '0;
    end
    else
    begin
      rng_cnt_ff <= rng_req ? (slow ? 9 : 2) : (rng_cnt_ff > 0 ? rng_cnt_ff - 1 : 0);
      hash_cnt_ff <= hash_req ? (slow ? 12 : 2) : (hash_cnt_ff > 0 ? hash_cnt_ff - 1 : 0);
      rng_done <= rng_cnt_ff == 1;
      hash_done <= hash_cnt_ff == 1;
      if (hash_req)
        dig_ff <= hash_msg[MSG_W-1 -: KEY_W] ^ DXOR;
    end
  end
endmodule : nd_engine_model

// >>> verif/nd_nonce_top_bench.sv
// Bench: drives the block as a bus host and checks every command form.
// Assumes the engine model as far side; expectations use its xor key.
`timescale 1ns/10ps
module nd_nonce_top_bench;
  import nd_pkg::*;
  localparam logic [KEY_W-1:0] RVAL = {8{32'h13579bdf}};
  localparam logic [KEY_W-1:0] DXOR = {8{32'h0f1e2d3c}};
  logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, cfg = 0, slow = 1, seed_seen;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, dat_o, q;
  logic ack, irq, rreq, seed, rdone, hreq, hdone, fk, sk;
  logic [KEY_W-1:0] rdata, dig, key;
  logic [MSG_W-1:0] msg, msg_seen;
  logic [47:0] serial = 48'h123456789abc, snf;
  logic [31:0] inw [8];
  int errors = 0, checks_done = 0, rng_seen = 0, n0;
  nd_nonce_top nd_nonce_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq), .CFG_LOCKED(cfg), .RNG_REQ(rreq),
    .RNG_SEED_UPDATE(seed), .RNG_DONE(rdone), .RNG_DATA(rdata), .HASH_REQ(hreq),
    .HASH_MSG(msg), .HASH_DONE(hdone), .HASH_DIGEST(dig), .SERIAL_NUMBER_BYTES(serial),
    .MAC_FIRST_KEY(fk), .MAC_SECOND_KEY(sk), .MAC_SN_FIELD(snf));
  nd_engine_model #(.RVAL(RVAL), .DXOR(DXOR)) nd_engine_model_inst (.clk(ref_clk),
    .rst_n(rst_n), .slow(slow), .rng_req(rreq), .rng_done(rdone), .rng_data(rdata),
    .hash_req(hreq), .hash_msg(msg), .hash_done(hdone), .hash_digest(dig));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (rreq === 1'b1)
    begin
      rng_seen++;
      seed_seen = seed;
    end
    if (hreq === 1'b1)
      msg_seen = msg;
  end
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chkw(input logic [MSG_W-1:0] got, input logic [MSG_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkw
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 100);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
    if (n >= 100)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk32(q, exp);
  endtask : rd
  // Loads the input words and settings, starts a command and waits for its event
  task automatic run(input logic [7:0] md, input logic [15:0] p2, input logic [5:0] len,
                     input logic [31:0] st);
    int n;
    for (int i = 0; i < 8; i++)
      wb(1'b1, ADR_HOST_IN + 8'(4 * i), inw[i]);
    wb(1'b1, ADR_IN_LEN, 32'(len));
    wb(1'b1, ADR_NONCE_MODE, 32'(md));
    wb(1'b1, ADR_SECOND_PARAMETER, 32'(p2));
    wb(1'b1, ADR_CTRL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300)
    begin
      chk32(32'(irq), 32'h1);
      report_and_stop();
    end
    rd(ADR_IRQ_STAT, st);
  endtask : run
  task automatic resp(input logic [KEY_W-1:0] exp);
    rd(ADR_RESP_LEN, 32'h20);
    for (int i = 0; i < 8; i++)
      rd(ADR_RESP + 8'(4 * i), exp[KEY_W-1-32*i -: 32]);
  endtask : resp
  task automatic new_input(input int k);
    for (int i = 0; i < 8; i++)
      inw[i] = 32'(32'h01010101 * (i + k));
  endtask : new_input
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADR_IN_LEN, 32'(RST_IN_LEN));
    rd(ADR_IRQ_MASK, 32'h0);
    rd(ADR_CTRL, 32'h0);
    wb(1'b1, 8'h60, 32'hffffffff);
    rd(8'h60, 32'h0);
    wb(1'b1, ADR_IRQ_MASK, 32'h3);
    new_input(1);
    run(8'h00, 16'h0, LEN_SHORT, 32'h1);
    chk32(32'(seed_seen), 32'h1);
    chkw(msg_seen, {{4{TEST_PATTERN}}, inw[0], inw[1], inw[2], inw[3], inw[4],
                    24'h160000});
    resp({4{TEST_PATTERN}});
    rd(ADR_CTRL, 32'h4);
    cfg <= 1'b1;
    slow <= 1'b0;
    new_input(2);
    run(8'h01, 16'h0, LEN_SHORT, 32'h1);
    chk32(32'(seed_seen), 32'h0);
    chkw(msg_seen, {RVAL, inw[0], inw[1], inw[2], inw[3], inw[4], 24'h160100});
    resp(RVAL);
    new_input(3);
    n0 = rng_seen;
    run(8'h03, 16'h0, LEN_FULL, 32'h1);
    key = {inw[0], inw[1], inw[2], inw[3], inw[4], inw[5], inw[6], inw[7]};
    rd(ADR_RESP_LEN, 32'h1);
    wb(1'b0, ADR_RESP, 32'h0);
    chk32(q & 32'hff000000, 32'h0);
    rd(ADR_CTRL, 32'hc);
    wb(1'b1, ADR_MAC_MODE, 32'h43);
    chk32(32'(irq), 32'h0);
    rd(ADR_IRQ_STAT, 32'h4);
    chk32(32'({fk, sk}), 32'h3);
    chkw(MSG_W'(snf), MSG_W'(serial));
    wb(1'b1, ADR_MAC_MODE, 32'h07);
    rd(ADR_IRQ_STAT, 32'h0);
    wb(1'b1, ADR_MAC_MODE, 32'h00);
    chk32(32'({fk, sk}), 32'h0);
    chkw(MSG_W'(snf), '0);
    run(8'h02, 16'h0, LEN_SHORT, 32'h2);
    run(8'h00, 16'h0, LEN_FULL, 32'h2);
    run(8'h03, 16'h0, LEN_SHORT, 32'h2);
    rd(ADR_CTRL, 32'he);
    rd(ADR_RESP_LEN, 32'h1);
    new_input(4);
    run(8'h00, 16'h8000, LEN_SHORT, 32'h1);
    chkw(msg_seen, {key, inw[0], inw[1], inw[2], inw[3], inw[4], 24'h160000});
    resp(key ^ DXOR);
    rd(ADR_CTRL, 32'hc);
    chk32(32'(rng_seen - n0), 32'h0);
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    wb(1'b1, ADR_NONCE_MODE, 32'h2);
    wb(1'b1, ADR_CTRL, 32'h1);
    repeat (6) @(posedge ref_clk);
    chk32(32'(irq), 32'h0);
    rd(ADR_IRQ_STAT, 32'h2);
    report_and_stop();
  end
endmodule : nd_nonce_top_bench
